// ---- include/lph_pkg.sv ----
package lph_pkg;

  // Bus protocol select patterns driven on the strap pins.
  localparam logic [1:0] PROTO_6800 = 2'h1;
  localparam logic [1:0] PROTO_8080 = 2'h0;

  // Core clock period and pin timing figures in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS = 60;
  localparam int PULSE_NS = 160;
  localparam int RECOVER_NS = 160;
  localparam int RESET_PULSE_NS = 1000;

  // Cycle counts; least times round up to whole cycles.
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the phase counter.
  localparam int CNT_W = 8;

  // Transfer state machine, Gray coded from LPH_IDLE through LPH_RECOVER; the step back to LPH_IDLE flips two bits.
  typedef enum logic [2:0] {
    LPH_IDLE = 3'h0,
    LPH_SETUP = 3'h1,
    LPH_PULSE = 3'h3,
    LPH_HOLD = 3'h2,
    LPH_RECOVER = 3'h6,
    LPH_RESET = 3'h4
  } lph_state_e;

endpackage

// ---- core/lph_skid_buf.sv ----
`timescale 1ns/100ps
module lph_skid_buf
  import lph_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock, reset and enable.
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Filling side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  // Two-entry circular buffer; full and empty come from the count.
  always_comb begin
    push = in_valid_in && (count != 2'h2);
    pop = (count != 2'h0) && out_ready_in;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  // Registers the buffer state.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (clk_en_in) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      mem <= next_mem;
    end
  end

  // Status is honest from the count.
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];

endmodule

// ---- core/lph_host.sv ----
`timescale 1ns/100ps
// Function
// - Strap pins pick protocol: 01 is 6800 style, 00 is 8080 style.
// - Device is selected only while chip select is low.
// - Data/command select high marks the byte as display data.
// - Data/command select low marks the byte as a command.
// - 8080 write strobe is active low; data captured at its rising edge.
// - 6800 enable pin is active high and qualifies each transfer.
// - 6800 direction pin high reads, low writes.
// - Reset pin optional; an unused pin is held high.
module lph_host
  import lph_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock, reset and enable.
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Protocol choice, also driven out to the strap pins.
  input wire logic [1:0] proto_sel_in,
  output logic [1:0] bus_protocol_select_out,
  // Write request stream: data, command flag, valid and ready.
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_is_data_in,
  // Read request.
  input wire logic rd_req_in,
  input wire logic rd_is_data_in,
  output logic rd_ack_out,
  // Read answer stream.
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [DATA_W-1:0] rd_data_out,
  // Device reset request and busy status.
  input wire logic dev_reset_req_in,
  output logic busy_out,
  // Device pins.
  output logic chip_select_n_out,
  output logic data_command_select_out,
  output logic read_strobe_or_enable_out,
  output logic write_or_direction_out,
  output logic device_reset_n_out,
  input wire logic [DATA_W-1:0] bus_data_in,
  output logic [DATA_W-1:0] bus_data_out,
  output logic bus_data_oe_n_out
);

  lph_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic is_read, next_is_read;
  logic [1:0] proto, next_proto;
  logic cs_n, next_cs_n, dc, next_dc, rs, next_rs, wd, next_wd;
  logic rst_n, next_rst_n, oe_n, next_oe_n, busy, next_busy;
  logic [DATA_W-1:0] dout, next_dout;
  logic wr_take, rd_push, next_rd_ack;
  logic [DATA_W-1:0] wr_data_q, rd_buf_data;
  logic wr_is_data_q, wr_valid_q, rd_buf_ready, wr_pop;

  // Write stream passes through a two-entry buffer so stalls lose nothing.
  lph_skid_buf #(.WIDTH(DATA_W + 1)) u_wr_buf (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .in_data_in({wr_is_data_in, wr_data_in}),
    .out_valid_out(wr_valid_q),
    .out_ready_in(wr_pop),
    .out_data_out({wr_is_data_q, wr_data_q})
  );

  // Read answers pass through a buffer; the user may stall them.
  lph_skid_buf #(.WIDTH(DATA_W)) u_rd_buf (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .in_valid_in(rd_push),
    .in_ready_out(rd_buf_ready),
    .in_data_in(bus_data_in),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_buf_data)
  );
  assign rd_data_out = rd_buf_data;

  // Phase helpers: idle strobe levels depend on protocol.
  function automatic logic idle_rs(input logic [1:0] p);
    idle_rs = (p == PROTO_8080);
  endfunction

  // Sequencer for transfers and reset pulses.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_read = is_read;
    next_proto = proto;
    next_cs_n = cs_n;
    next_dc = dc;
    next_rs = rs;
    next_wd = wd;
    next_rst_n = rst_n;
    next_oe_n = oe_n;
    next_busy = busy;
    next_dout = dout;
    next_rd_ack = 1'b0;
    wr_take = 1'b0;
    rd_push = 1'b0;
    case (state)
      LPH_IDLE: begin
        next_proto = proto_sel_in;
        next_rs = idle_rs(proto_sel_in);
        next_wd = (proto_sel_in == PROTO_8080);
        next_cs_n = 1'b1;
        next_oe_n = 1'b1;
        next_busy = 1'b0;
        next_cnt = '0;
        if (dev_reset_req_in) begin
          next_rst_n = 1'b0;
          next_busy = 1'b1;
          next_state = LPH_RESET;
        end else if (rd_req_in && rd_buf_ready) begin
          next_rd_ack = 1'b1;
          next_is_read = 1'b1;
          next_cs_n = 1'b0;
          next_dc = rd_is_data_in;
          next_oe_n = 1'b1;
          // Reads keep the direction pin high in both protocols.
          next_wd = 1'b1;
          next_busy = 1'b1;
          next_state = LPH_SETUP;
        end else if (wr_valid_q) begin
          wr_take = 1'b1;
          next_is_read = 1'b0;
          next_cs_n = 1'b0;
          next_dc = wr_is_data_q;
          next_dout = wr_data_q;
          next_oe_n = 1'b0;
          next_wd = (proto_sel_in == PROTO_8080);
          next_busy = 1'b1;
          next_state = LPH_SETUP;
        end
      end
      LPH_SETUP: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == CNT_W'(SETUP_CYC - 1)) begin
          next_cnt = '0;
          if (proto == PROTO_8080) begin
            // One strobe at a time, never both.
            if (is_read) begin
              next_rs = 1'b0;
            end else begin
              next_wd = 1'b0;
            end
          end else begin
            next_rs = 1'b1;
          end
          next_state = LPH_PULSE;
        end
      end
      LPH_PULSE: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == CNT_W'(PULSE_CYC - 1)) begin
          next_cnt = '0;
          rd_push = is_read;
          next_rs = idle_rs(proto);
          next_wd = (proto == PROTO_8080);
          next_state = LPH_HOLD;
        end
      end
      LPH_HOLD: begin
        next_cs_n = 1'b1;
        next_oe_n = 1'b1;
        next_state = LPH_RECOVER;
      end
      LPH_RECOVER: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == CNT_W'(RECOVER_CYC - 1)) begin
          next_cnt = '0;
          next_state = LPH_IDLE;
        end
      end
      LPH_RESET: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == CNT_W'(RESET_CYC - 1)) begin
          next_cnt = '0;
          next_rst_n = 1'b1;
          next_state = LPH_RECOVER;
        end
      end
      default: begin
        next_state = LPH_IDLE;
      end
    endcase
  end
  assign wr_pop = wr_take;

  // Registers every pin and state bit.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state <= LPH_IDLE;
      cnt <= '0;
      is_read <= 1'b0;
      proto <= PROTO_8080;
      cs_n <= 1'b1;
      dc <= 1'b0;
      rs <= 1'b1;
      wd <= 1'b1;
      rst_n <= 1'b1;
      oe_n <= 1'b1;
      busy <= 1'b0;
      dout <= '0;
      rd_ack_out <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      cnt <= next_cnt;
      is_read <= next_is_read;
      proto <= next_proto;
      cs_n <= next_cs_n;
      dc <= next_dc;
      rs <= next_rs;
      wd <= next_wd;
      rst_n <= next_rst_n;
      oe_n <= next_oe_n;
      busy <= next_busy;
      dout <= next_dout;
      rd_ack_out <= next_rd_ack;
    end
  end

  assign bus_protocol_select_out = proto;
  assign chip_select_n_out = cs_n;
  assign data_command_select_out = dc;
  assign read_strobe_or_enable_out = rs;
  assign write_or_direction_out = wd;
  assign device_reset_n_out = rst_n;
  assign bus_data_out = dout;
  assign bus_data_oe_n_out = oe_n;
  assign busy_out = busy;

  // Checks on the pin sequence.
  AST_NO_BOTH_STROBES: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (proto == PROTO_8080) |-> (rs || wd))
    else $error("both strobes asserted");
  AST_STROBE_NEEDS_CS: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    ((proto == PROTO_8080) && !(rs && wd)) |-> !cs_n)
    else $error("strobe without chip select");
  AST_READ_RELEASES: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (proto == PROTO_8080 && !rs) |-> oe_n)
    else $error("host drives bus during read");
  AST_WRITE_PULSE: assert property (@(posedge core_clk_in)
    disable iff (reset_in || !clk_en_in)
    (proto == PROTO_8080 && $fell(wd)) |-> !wd [*4])
    else $error("write pulse too short");
  AST_ENABLE_6800: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (proto == PROTO_6800 && rs) |-> !cs_n)
    else $error("enable high while deselected");
  AST_DIR_6800: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (proto == PROTO_6800 && rs) |-> (wd == is_read))
    else $error("direction wrong during enable");
  AST_RESET_PULSE: assert property (@(posedge core_clk_in)
    disable iff (reset_in || !clk_en_in)
    $fell(rst_n) |-> !rst_n [*8])
    else $error("device reset pulse too short");
  AST_WRITE_DRIVES: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (proto == PROTO_8080 && !wd) |-> !oe_n)
    else $error("bus not driven during write");
  AST_PROTO_LEGAL: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (state != LPH_IDLE) |-> (proto == PROTO_6800 || proto == PROTO_8080))
    else $error("illegal protocol select");

  COV_WRITE: cover property (@(posedge core_clk_in)
    disable iff (reset_in) wr_take);
  COV_READ: cover property (@(posedge core_clk_in)
    disable iff (reset_in) rd_push);
  COV_RESET: cover property (@(posedge core_clk_in)
    disable iff (reset_in) $rose(rst_n));
  COV_READ_6800: cover property (@(posedge core_clk_in)
    disable iff (reset_in) (proto == PROTO_6800) && rd_push);

  // Counts how long the device reset pin has been held low.
  logic [CNT_W-1:0] rst_low_cnt;
  always_ff @(posedge core_clk_in) begin
    if (reset_in || rst_n) begin
      rst_low_cnt <= '0;
    end else if (clk_en_in) begin
      rst_low_cnt <= rst_low_cnt + CNT_W'(1);
    end
  end

  // The whole pulse must last exactly the reset count, not just start.
  AST_RESET_LENGTH: assert property (@(posedge core_clk_in)
    disable iff (reset_in || !clk_en_in)
    $rose(rst_n) |-> (rst_low_cnt == CNT_W'(RESET_CYC)))
    else $error("device reset pulse length wrong");

endmodule

// ---- testbench/lph_dev_model.sv ----
`timescale 1ns/100ps
module lph_dev_model
  import lph_pkg::*;
#(
  parameter logic [7:0] RD_DISP = 8'hA5,
  parameter logic [7:0] RD_CTRL = 8'h3C,
  parameter int FILT_CYC = 3
) (
  // Clock and host pins.
  input wire logic core_clk_in,
  input wire logic [1:0] proto_in,
  input wire logic cs_n_in,
  input wire logic dc_in,
  input wire logic en_in,
  input wire logic wd_in,
  input wire logic rst_n_in,
  input wire logic [7:0] host_data_in,
  input wire logic host_oe_n_in,
  // Wire level and what the device took.
  output logic [7:0] level_out,
  output logic drive_out,
  output logic [7:0] got_data_out,
  output logic got_dc_out,
  output int got_count_out
);
  logic m68;
  logic prev_en;
  logic prev_wd;
  logic [7:0] last = 8'h00;
  int low_cyc;
  // The device answers only while selected and strobed for a read.
  assign m68 = (proto_in == PROTO_6800);
  assign drive_out = !cs_n_in && (m68 ? en_in && wd_in : !en_in);
  // A free line shows the inverse of its last level, so it toggles and old data returns every other cycle.
  always_comb begin
    if (!host_oe_n_in) begin
      level_out = host_data_in;
    end else if (drive_out) begin
      level_out = dc_in ? RD_DISP : RD_CTRL;
    end else begin
      level_out = ~last;
    end
  end
  // Filtered reset, then writes at the closing edge of the strobe.
  always @(posedge core_clk_in) begin
    last <= level_out;
    prev_en <= en_in;
    prev_wd <= wd_in;
    low_cyc <= rst_n_in ? 0 : low_cyc + 1;
    if (low_cyc >= FILT_CYC) begin
      got_data_out <= 8'h00;
      got_dc_out <= 1'b0;
    end else if (!cs_n_in && (m68 ? prev_en && !en_in && !wd_in
        : !prev_wd && wd_in)) begin
      got_data_out <= level_out;
      got_dc_out <= dc_in;
      got_count_out <= got_count_out + 1;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench
  import lph_pkg::*;
;
  localparam logic [7:0] RD_DISP = 8'hA5;
  localparam logic [7:0] RD_CTRL = 8'h3C;
  logic clk, rst, wv, wr, wdc, rq, rdc, ack, rv, rr, drq, busy, ok, ce;
  logic cs_n, dc, en, wd, rst_n, oe_n, drive, got_dc;
  logic [1:0] proto, pins;
  logic [7:0] wdat, rdat, level, hdat, got;
  int got_n, stalls, n_mismatch, checks_done;
  lph_host dut (.core_clk_in(clk), .reset_in(rst), .clk_en_in(ce),
    .proto_sel_in(proto), .bus_protocol_select_out(pins),
    .wr_valid_in(wv), .wr_ready_out(wr), .wr_data_in(wdat),
    .wr_is_data_in(wdc), .rd_req_in(rq), .rd_is_data_in(rdc),
    .rd_ack_out(ack), .rd_valid_out(rv), .rd_ready_in(rr),
    .rd_data_out(rdat), .dev_reset_req_in(drq), .busy_out(busy),
    .chip_select_n_out(cs_n), .data_command_select_out(dc),
    .read_strobe_or_enable_out(en), .write_or_direction_out(wd),
    .device_reset_n_out(rst_n), .bus_data_in(level),
    .bus_data_out(hdat), .bus_data_oe_n_out(oe_n));
  lph_dev_model #(.RD_DISP(RD_DISP), .RD_CTRL(RD_CTRL)) dev (
    .core_clk_in(clk), .proto_in(pins), .cs_n_in(cs_n), .dc_in(dc),
    .en_in(en), .wd_in(wd), .rst_n_in(rst_n), .host_data_in(hdat),
    .host_oe_n_in(oe_n), .level_out(level), .drive_out(drive),
    .got_data_out(got), .got_dc_out(got_dc), .got_count_out(got_n));
  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic c, input string what);
    checks_done++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Offer a byte until taken; the caller lowers valid after the last.
  task automatic send(input logic d, input logic [7:0] v);
    int n = 0;
    wv = 1'b1;
    wdc = d;
    wdat = v;
    @(negedge clk);
    while (!wr && n < 60) begin
      n++;
      stalls++;
      @(negedge clk);
    end
    check(wr === 1'b1, "write accepted");
    step(1);
  endtask
  // Waits for the device to take one more byte; a timeout is a mismatch.
  task automatic wait_got(input int c0);
    int n = 0;
    while (got_n == c0 && n < 60) begin
      n++;
      step(1);
    end
    check(got_n != c0, "write reached device");
  endtask
  task automatic t_write(input logic [1:0] p, input logic d,
      input logic [7:0] v);
    int c0;
    proto = p;
    step(10);
    c0 = got_n;
    send(d, v);
    wv = 1'b0;
    wait_got(c0);
    check(got === v && got_dc === d, "write byte");
    check(pins === p, "protocol pins");
    $display("write test done");
  endtask
  task automatic rd_issue(input logic d, output logic acked);
    int n = 0;
    step(1);
    rq = 1'b1;
    rdc = d;
    @(negedge clk);
    while (!ack && n < 40) begin
      n++;
      @(negedge clk);
    end
    acked = ack;
    step(1);
    rq = 1'b0;
  endtask
  task automatic rd_expect(input logic [7:0] v);
    int n = 0;
    @(negedge clk);
    while (!rv && n < 40) begin
      n++;
      @(negedge clk);
    end
    check(rv === 1'b1 && rdat === v, "read byte");
    step(1);
  endtask
  task automatic t_read(input logic [1:0] p, input logic d);
    proto = p;
    rr = 1'b1;
    step(10);
    rd_issue(d, ok);
    check(ok === 1'b1, "read taken");
    rd_expect(d ? RD_DISP : RD_CTRL);
    $display("read test done");
  endtask
  // Stalled reader: two answers fill the buffer, the third is refused.
  task automatic t_read_full();
    proto = PROTO_8080;
    rr = 1'b0;
    step(10);
    rd_issue(1'b1, ok);
    rd_issue(1'b0, ok);
    rd_issue(1'b1, ok);
    check(ok === 1'b0, "read refused while full");
    rr = 1'b1;
    rd_expect(RD_DISP);
    rd_expect(RD_CTRL);
    check(rv === 1'b0, "read buffer empty");
    $display("read full test done");
  endtask
  task automatic t_burst();
    logic [7:0] v [4] = '{8'h00, 8'hFF, 8'h81, 8'h7E};
    int c0;
    proto = PROTO_8080;
    step(10);
    stalls = 0;
    c0 = got_n;
    fork
      begin
        foreach (v[i]) send(1'b1, v[i]);
        wv = 1'b0;
      end
      foreach (v[i]) begin
        wait_got(c0 + i);
        check(got === v[i], "burst order");
      end
    join
    check(stalls > 0, "writes held back when full");
    $display("burst test done");
  endtask
  // Clock enable low freezes a write in mid pulse; it then completes.
  task automatic t_freeze();
    logic [3:0] pins_q;
    int c0;
    proto = PROTO_8080;
    step(10);
    c0 = got_n;
    send(1'b1, 8'h96);
    wv = 1'b0;
    step(3);
    pins_q = {cs_n, en, wd, oe_n};
    ce = 1'b0;
    step(20);
    check({cs_n, en, wd, oe_n} === pins_q && got_n == c0, "frozen");
    ce = 1'b1;
    wait_got(c0);
    check(got === 8'h96 && got_dc === 1'b1, "write after freeze");
    $display("freeze test done");
  endtask
  task automatic t_dev_reset();
    int n = 0;
    step(10);
    drq = 1'b1;
    step(1);
    drq = 1'b0;
    @(negedge clk);
    while (rst_n && n < 20) begin
      n++;
      @(negedge clk);
    end
    check(busy === 1'b1, "busy during device reset");
    n = 0;
    while (!rst_n && n < 100) begin
      n++;
      @(negedge clk);
    end
    check(n == RESET_CYC, "reset pulse length");
    check(got === 8'h00 && got_dc === 1'b0, "defaults");
    step(1);
    $display("reset test done");
  endtask
  // Pin watch: strobe overlap, contention, strobes while deselected.
  always @(negedge clk) begin
    if (!rst && pins === PROTO_8080 && !en && !wd) begin
      check(1'b0, "both strobes low");
    end
    if (!rst && !oe_n && drive) begin
      check(1'b0, "bus contention");
    end
    if (!rst && pins === PROTO_8080 && cs_n && !(en && wd)) begin
      check(1'b0, "strobe while deselected");
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    proto = PROTO_8080;
    {wv, wdc, rq, rdc, drq, rr} = 6'h01;
    ce = 1'b1;
    wdat = 8'h00;
    step(4);
    check(cs_n === 1'b1 && oe_n === 1'b1 && rst_n === 1'b1, "rst");
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      t_write(i[1] ? PROTO_6800 : PROTO_8080, i[0], 8'h5A ^ 8'(i));
      t_read(i[1] ? PROTO_6800 : PROTO_8080, i[0]);
    end
    t_burst();
    t_freeze();
    t_read_full();
    t_dev_reset();
    t_write(PROTO_8080, 1'b1, 8'hC3);
    complete_run();
  end
endmodule
